// ---- shared/ddrwz_pkg.sv ----
`default_nettype none
package ddrwz_pkg;
   localparam int          CMD_W = 3;
   localparam logic [2:0]  CMD_NOP  = 3'h0;
   localparam logic [2:0]  CMD_WR   = 3'h1;
   localparam logic [2:0]  CMD_RD   = 3'h2;
   localparam logic [2:0]  CMD_ACT  = 3'h3;
   localparam logic [2:0]  CMD_PRE  = 3'h4;
   localparam logic [2:0]  CMD_PREA = 3'h5;
   localparam logic [2:0]  CMD_ZQL  = 3'h6;
   localparam logic [2:0]  CMD_ZQS  = 3'h7;

   // Burst field of the burst mode register.
   localparam logic [1:0]  BF_FULL8 = 2'h0;
   localparam logic [1:0]  BF_OTF   = 2'h1;
   localparam logic [1:0]  BF_CHOP4 = 2'h2;

   // Data clocks per burst: two beats per clock.
   localparam logic [3:0]  DCLK_FULL8 = 4'h4;
   localparam logic [3:0]  DCLK_CHOP4 = 4'h2;

   localparam logic [4:0]  CWL_FORBID = 5'h09;
   localparam logic [4:0]  CWL_OFFSET = 5'h02;

   // All times below are in command clocks (nCK).
   localparam int          CK_PER_NCK       = 1;
   localparam int          T_ZQ_INIT_NCK    = 1024;
   localparam int          T_ZQ_OPER_NCK    = 512;
   localparam int          T_SHORT_CALIBRATION_COMMAND_NCK       = 128;
   localparam int          T_ZQ_CORR_NCK    = 64;
   localparam logic [10:0] ZQ_INIT_CYC = 11'(T_ZQ_INIT_NCK * CK_PER_NCK);
   localparam logic [10:0] ZQ_OPER_CYC = 11'(T_ZQ_OPER_NCK * CK_PER_NCK);
   localparam logic [10:0] SHORT_CALIBRATION_COMMAND_CYC    = 11'(T_SHORT_CALIBRATION_COMMAND_NCK * CK_PER_NCK);
   localparam logic [10:0] ZQ_CORR_CYC = 11'(T_ZQ_CORR_NCK * CK_PER_NCK);

   localparam logic [3:0]  CCD_S_NCK = 4'h4;
   localparam logic [3:0]  CCD_L_NCK = 4'h6;
   localparam logic [3:0]  CCD_SAT   = 4'hF;
   localparam logic [4:0]  WR_NCK           = 5'h0C;
   localparam logic [4:0]  WR_CRC_DM_NCK    = 5'h0E;
   localparam logic [4:0]  WTR_S_NCK        = 5'h03;
   localparam logic [4:0]  WTR_L_NCK        = 5'h09;
   localparam logic [4:0]  WTR_S_CRC_DM_NCK = 5'h05;
   localparam logic [4:0]  WTR_L_CRC_DM_NCK = 5'h0B;

   typedef enum logic {ZQ_IDLE = 1'b0, ZQ_CAL = 1'b1} ddrwz_zq_st_t;
endpackage
`default_nettype wire

// ---- verilog/ddrwz_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddrwz_sync
(
   input  wire logic dst_clk, // Destination clock.
   input  wire logic rst_n,   // Asynchronous reset, active low.
   input  wire logic d_in,    // Level from the other domain.
   output logic      d_out    // Synchronised level.
);
   import ddrwz_pkg::*;

   typedef struct packed
   {
      logic s1;
      logic s2;
   } ddrwz_sync_t;

   ddrwz_sync_t sync_reg;
   ddrwz_sync_t sync_next;

   always_comb
   begin
      sync_next.s1 = d_in;
      sync_next.s2 = sync_reg.s1;
   end

   always_ff @(posedge dst_clk or negedge rst_n)
   begin
      if (!rst_n)
         sync_reg <= '0;
      else
         sync_reg <= sync_next;
   end

   assign d_out = sync_reg.s2;
endmodule
`default_nettype wire

// ---- verilog/ddrwz_core.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddrwz_core
(
   input  wire logic                        sys_clk,     // Command clock.
   input  wire logic                        rst_n,       // Asynchronous reset, active low.
   input  wire logic                        cmd_valid,   // Command present this clock.
   input  wire logic [ddrwz_pkg::CMD_W-1:0] cmd_code,    // Command code.
   input  wire logic [1:0]                  cmd_bg,      // Bank group.
   input  wire logic [1:0]                  cmd_ba,      // Bank within group.
   input  wire logic                        chop_bit,    // Chop address bit at the write.
   input  wire logic [1:0]                  burst_field, // Burst mode register burst field.
   input  wire logic [4:0]                  column_write_latency,         // Column write latency.
   input  wire logic                        two_pre,     // Two-clock write preamble mode.
   input  wire logic                        crc_en,      // Write CRC enabled.
   input  wire logic                        dm_en,       // Data mask enabled.
   input  wire logic                        dqs_clk,     // Data strobe clock.
   input  wire logic                        dq_beat,     // Beat valid on the strobe.
   input  wire logic                        dq_last,     // Last beat of the burst.
   input  wire logic [7:0]                  dq,          // Beat data.
   input  wire logic                        setup_err,   // Data setup or hold violated.
   input  wire logic                        strobe_err,  // Strobe width or position violated.
   output logic                             cmd_ack,     // Command accepted.
   output logic                             cmd_rej,     // Command refused.
   output logic                             data_win,    // Write data window open.
   output logic                             burst_chop,  // Current burst is chopped.
   output logic                             rec_busy,    // Write recovery running.
   output logic                             wtr_s_busy,  // Short write-to-read running.
   output logic                             wtr_l_busy,  // Long write-to-read running.
   output logic                             st_valid,    // Burst stored.
   output logic [63:0]                      st_data,     // Stored burst data.
   output logic                             st_ok,       // Stored data is trustworthy.
   output logic                             offend,      // An offending write is pending.
   output logic                             hang_risk,   // Violation outside containment.
   output logic                             cfg_err,     // Latency illegal for preamble.
   output logic                             zq_busy,     // Calibration window open.
   output logic                             zq_load,     // New values loaded into I/O.
   output logic                             zq_curr_en,  // Calibration current path on.
   output logic                             park_hold    // Park termination held.
);
   import ddrwz_pkg::*;

   typedef struct packed
   {
      logic [31:0]  wpipe;
      logic [31:0]  cpipe;
      logic [3:0]   dat_cnt;
      logic         cur_chop;
      logic         data_win;
      logic [4:0]   rec_cnt;
      logic [4:0]   wtrs_cnt;
      logic [4:0]   wtrl_cnt;
      logic         rec_b;
      logic         wtrs_b;
      logic         wtrl_b;
      logic [15:0]  open_bk;
      logic [1:0]   last_grp;
      logic [3:0]   ccd_el;
      logic         offend;
      logic         hang;
      logic         cfg_err;
      logic         tog_seen;
      logic [63:0]  st_data;
      logic         st_valid;
      logic         st_ok;
      ddrwz_zq_st_t zst;
      logic         zq_short;
      logic [10:0]  zq_win;
      logic [10:0]  zq_el;
      logic         zq_first;
      logic         zq_load;
      logic         zq_curr;
      logic         park;
      logic         ack;
      logic         rej;
   } ddrwz_sys_t;

   typedef struct packed
   {
      logic [63:0] word;
      logic [63:0] held;
      logic        e_s;
      logic        e_t;
      logic        h_s;
      logic        h_t;
      logic        tog;
   } ddrwz_lnk_t;

   ddrwz_sys_t sys_reg;
   ddrwz_sys_t sys_next;
   ddrwz_lnk_t lnk_reg;
   ddrwz_lnk_t lnk_next;

   logic       tog_s;
   logic       done;
   logic       bad;
   logic       ok;
   logic       acc;
   logic       is_wr;
   logic       trig;
   logic       crc_dm;
   logic [4:0] cwl_idx;
   logic [3:0] ccd_need;
   logic [3:0] bk_idx;
   logic [10:0] zq_lim;

   function automatic logic is_chop(input logic [1:0] field, input logic abit);
      is_chop = (field == BF_CHOP4) || ((field == BF_OTF) && !abit);
   endfunction

   // Six-clock spacing becomes seven in two-clock preamble mode.
   function automatic logic [3:0] ccd_long(input logic tp);
      ccd_long = (tp && (CCD_L_NCK == 4'h6)) ? 4'(CCD_L_NCK + 4'h1) : CCD_L_NCK;
   endfunction

   // Link side: beats are gathered on the strobe clock and the finished burst is
   // handed over with a toggle; the held word stays put until the next burst ends.
   always_comb
   begin
      lnk_next = lnk_reg;
      if (dq_beat)
      begin
         lnk_next.word = {lnk_reg.word[55:0], dq};
         lnk_next.e_s = lnk_reg.e_s | setup_err;
         lnk_next.e_t = lnk_reg.e_t | strobe_err;
         if (dq_last)
         begin
            lnk_next.held = lnk_next.word;
            lnk_next.h_s = lnk_next.e_s;
            lnk_next.h_t = lnk_next.e_t;
            lnk_next.tog = ~lnk_reg.tog;
            lnk_next.word = '0;
            lnk_next.e_s = 1'b0;
            lnk_next.e_t = 1'b0;
         end
      end
   end

   always_ff @(posedge dqs_clk or negedge rst_n)
   begin
      if (!rst_n)
         lnk_reg <= '0;
      else
         lnk_reg <= lnk_next;
   end

   ddrwz_sync u_tog_sync
   (
      .dst_clk (sys_clk),
      .rst_n   (rst_n),
      .d_in    (lnk_reg.tog),
      .d_out   (tog_s)
   );

   assign done = tog_s ^ sys_reg.tog_seen;
   assign bad = lnk_reg.h_s | lnk_reg.h_t;
   assign is_wr = (cmd_code == CMD_WR);
   assign bk_idx = {cmd_bg, cmd_ba};
   assign cwl_idx = column_write_latency - CWL_OFFSET;
   assign trig = sys_reg.wpipe[cwl_idx];
   assign crc_dm = crc_en & dm_en;
   assign ccd_need = (cmd_bg == sys_reg.last_grp) ? ccd_long(two_pre) : CCD_S_NCK;
   assign zq_lim = sys_reg.zq_short ? ZQ_CORR_CYC : sys_reg.zq_win;

   always_comb
   begin
      case (cmd_code)
         CMD_WR:           ok = (sys_reg.ccd_el >= ccd_need);
         CMD_ZQL, CMD_ZQS: ok = (sys_reg.open_bk == 16'h0000);
         default:          ok = 1'b1;
      endcase
      ok = ok && (sys_reg.zst == ZQ_IDLE);
      acc = cmd_valid && ok;
   end

   always_comb
   begin
      sys_next = sys_reg;
      sys_next.ack = acc;
      sys_next.rej = cmd_valid && !ok;
      sys_next.zq_load = 1'b0;
      sys_next.st_valid = 1'b0;
      sys_next.tog_seen = tog_s;
      sys_next.cfg_err = two_pre && (column_write_latency == CWL_FORBID);
      sys_next.wpipe = {sys_reg.wpipe[30:0], acc && is_wr};
      sys_next.cpipe = {sys_reg.cpipe[30:0], acc && is_wr && is_chop(burst_field, chop_bit)};
      if (acc && is_wr)
      begin
         // The accepting clock counts as one, so a write exactly one delay later is taken.
         sys_next.ccd_el = 4'h1;
         sys_next.last_grp = cmd_bg;
      end
      else if (sys_reg.ccd_el != CCD_SAT)
         sys_next.ccd_el = sys_reg.ccd_el + 4'h1;
      // A seamless follow-on burst restarts the data count without a recovery gap.
      if (trig)
      begin
         sys_next.cur_chop = sys_reg.cpipe[cwl_idx];
         sys_next.dat_cnt = sys_reg.cpipe[cwl_idx] ? DCLK_CHOP4 : DCLK_FULL8;
      end
      else if (sys_reg.dat_cnt != 4'h0)
         sys_next.dat_cnt = sys_reg.dat_cnt - 4'h1;
      sys_next.data_win = (sys_next.dat_cnt != 4'h0);
      if ((sys_reg.dat_cnt == 4'h1) && !trig)
      begin
         sys_next.rec_cnt = crc_dm ? WR_CRC_DM_NCK : WR_NCK;
         sys_next.wtrs_cnt = crc_dm ? WTR_S_CRC_DM_NCK : WTR_S_NCK;
         sys_next.wtrl_cnt = crc_dm ? WTR_L_CRC_DM_NCK : WTR_L_NCK;
      end
      else
      begin
         if (sys_reg.rec_cnt != 5'h00)
            sys_next.rec_cnt = sys_reg.rec_cnt - 5'h01;
         if (sys_reg.wtrs_cnt != 5'h00)
            sys_next.wtrs_cnt = sys_reg.wtrs_cnt - 5'h01;
         if (sys_reg.wtrl_cnt != 5'h00)
            sys_next.wtrl_cnt = sys_reg.wtrl_cnt - 5'h01;
      end
      sys_next.rec_b = (sys_next.rec_cnt != 5'h00);
      sys_next.wtrs_b = (sys_next.wtrs_cnt != 5'h00);
      sys_next.wtrl_b = (sys_next.wtrl_cnt != 5'h00);
      if (acc && (cmd_code == CMD_ACT))
         sys_next.open_bk[bk_idx] = 1'b1;
      if (acc && (cmd_code == CMD_PRE))
         sys_next.open_bk[bk_idx] = 1'b0;
      if (acc && (cmd_code == CMD_PREA))
         sys_next.open_bk = 16'h0000;
      if (acc && ((cmd_code == CMD_PRE) || (cmd_code == CMD_PREA)) && (sys_next.open_bk == 16'h0000))
         sys_next.offend = 1'b0;
      if (done)
      begin
         // A corrupt burst is only marked; the command path keeps running.
         sys_next.st_valid = 1'b1;
         sys_next.st_data = lnk_reg.held;
         sys_next.st_ok = !bad && !sys_next.offend;
         if (bad)
            sys_next.offend = 1'b1;
         if (lnk_reg.h_t && (crc_en || (burst_field == BF_OTF)))
            sys_next.hang = 1'b1;
      end
      case (sys_reg.zst)
         ZQ_IDLE:
         begin
            // The loop lock state is not consulted, so calibration may overlap locking.
            if (acc && ((cmd_code == CMD_ZQL) || (cmd_code == CMD_ZQS)))
            begin
               sys_next.zst = ZQ_CAL;
               sys_next.zq_el = 11'h000;
               sys_next.zq_curr = 1'b1;
               sys_next.park = 1'b1;
               sys_next.zq_short = (cmd_code == CMD_ZQS);
               if (cmd_code == CMD_ZQS)
                  sys_next.zq_win = SHORT_CALIBRATION_COMMAND_CYC;
               else
               begin
                  sys_next.zq_win = sys_reg.zq_first ? ZQ_OPER_CYC : ZQ_INIT_CYC;
                  sys_next.zq_first = 1'b1;
               end
            end
         end
         ZQ_CAL:
         begin
            sys_next.zq_el = sys_reg.zq_el + 11'h001;
            if (sys_reg.zq_el == zq_lim - 11'h001)
            begin
               sys_next.zq_load = 1'b1;
               sys_next.zq_curr = 1'b0;
            end
            if (sys_reg.zq_el == sys_reg.zq_win - 11'h001)
            begin
               sys_next.zst = ZQ_IDLE;
               sys_next.park = 1'b0;
            end
         end
         default:
            sys_next.zst = ZQ_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         sys_reg <= '{ccd_el: CCD_SAT, zst: ZQ_IDLE, default: '0};
      else
         sys_reg <= sys_next;
   end

   assign cmd_ack    = sys_reg.ack;
   assign cmd_rej    = sys_reg.rej;
   assign data_win   = sys_reg.data_win;
   assign burst_chop = sys_reg.cur_chop;
   assign rec_busy   = sys_reg.rec_b;
   assign wtr_s_busy = sys_reg.wtrs_b;
   assign wtr_l_busy = sys_reg.wtrl_b;
   assign st_valid   = sys_reg.st_valid;
   assign st_data    = sys_reg.st_data;
   assign st_ok      = sys_reg.st_ok;
   assign offend     = sys_reg.offend;
   assign hang_risk  = sys_reg.hang;
   assign cfg_err    = sys_reg.cfg_err;
   assign zq_busy    = sys_reg.zst;
   assign zq_load    = sys_reg.zq_load;
   assign zq_curr_en = sys_reg.zq_curr;
   assign park_hold  = sys_reg.park;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   a_full_burst: assert property (acc && is_wr && !is_chop(burst_field, chop_bit)
      |=> sys_reg.wpipe[0] && !sys_reg.cpipe[0]) else $error("eight-beat write was chopped");
   a_otf_chop: assert property (acc && is_wr && burst_field == BF_OTF && !chop_bit
      |=> sys_reg.cpipe[0]) else $error("on-the-fly chop missed");
   a_fixed_chop: assert property (acc && is_wr && burst_field == BF_CHOP4
      |=> sys_reg.cpipe[0]) else $error("fixed chop missed");
   a_rec_plain: assert property (sys_reg.dat_cnt == 4'h1 && !trig && !crc_dm
      |=> sys_reg.rec_cnt == WR_NCK && sys_reg.wtrl_cnt == WTR_L_NCK ##1 rec_busy)
      else $error("recovery not started after last data");
   a_rec_crcdm: assert property (sys_reg.dat_cnt == 4'h1 && !trig && crc_dm
      |=> sys_reg.rec_cnt == WR_CRC_DM_NCK && sys_reg.wtrs_cnt == WTR_S_CRC_DM_NCK)
      else $error("crc-mask delays not used");
   a_bad_store: assert property (done && bad |=> st_valid && !st_ok && offend)
      else $error("corrupt burst not marked");
   a_hang_mark: assert property (done && lnk_reg.h_t && crc_en |=> hang_risk)
      else $error("uncontained violation not flagged");
   a_rd_taken: assert property (cmd_valid && cmd_code == CMD_RD && sys_reg.zst == ZQ_IDLE
      |=> cmd_ack && !cmd_rej) else $error("read refused");
   a_same_grp: assert property (cmd_valid && is_wr && cmd_bg == sys_reg.last_grp
      && sys_reg.ccd_el >= ccd_long(two_pre) && sys_reg.zst == ZQ_IDLE |=> cmd_ack)
      else $error("write refused after long column delay");
   a_other_grp: assert property (cmd_valid && is_wr && cmd_bg != sys_reg.last_grp
      && sys_reg.ccd_el >= CCD_S_NCK && sys_reg.zst == ZQ_IDLE |=> cmd_ack)
      else $error("write refused after short column delay");
   a_offend_clr: assert property (acc && cmd_code == CMD_PREA && !done |=> !offend)
      else $error("offending mark kept after all banks idle");
   a_zq_first: assert property (acc && cmd_code == CMD_ZQL && !sys_reg.zq_first
      |=> sys_reg.zq_win == ZQ_INIT_CYC && zq_busy) else $error("first calibration time wrong");
   a_zq_short: assert property (acc && cmd_code == CMD_ZQS |-> ##65 zq_load)
      else $error("short calibration load late");
   a_zq_curr: assert property (zq_load |-> !zq_curr_en && $past(zq_curr_en))
      else $error("calibration current left on");
endmodule
`default_nettype wire

// ---- verif/ddrwz_dqs_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ddrwz_dqs_model
(
   output logic       dqs_clk,    // Strobe, still between bursts.
   output logic       dq_beat,    // Beat valid.
   output logic       dq_last,    // Last beat of the burst.
   output logic [7:0] dq,         // Beat data.
   output logic       setup_err,  // Setup or hold violated.
   output logic       strobe_err  // Strobe violated.
);
   initial
   begin
      dqs_clk = 1'b0;
      dq_beat = 1'b0;
      dq_last = 1'b0;
      dq = 8'h00;
      setup_err = 1'b0;
      strobe_err = 1'b0;
   end

   // The burst starts a few ns after the window opens, inside the tolerated strobe range.
   task automatic send(input logic [63:0] d, input int n, input logic se, input logic be);
      #7;
      for (int i = 0; i < n; i++)
      begin
         dq = d[63-8*i -: 8];
         dq_beat = 1'b1;
         dq_last = (i == n - 1);
         setup_err = se;
         strobe_err = be;
         #8 dqs_clk = 1'b1;
         #16 dqs_clk = 1'b0;
         #8;
      end
      // A released data line shows the inverse, so stale data never looks valid.
      dq = ~dq;
      dq_beat = 1'b0;
      dq_last = 1'b0;
      setup_err = 1'b0;
      strobe_err = 1'b0;
   endtask
endmodule
`default_nettype wire

// ---- verif/ddrwz_core_test.sv ----
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin err_count++; \
   $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, e); end end
module ddrwz_core_test;
   import ddrwz_pkg::*;
   logic        sys_clk, rst_n, cmd_valid, chop_bit, two_pre, crc_en, dm_en;
   logic [2:0]  cmd_code;
   logic [1:0]  cmd_bg, cmd_ba, burst_field;
   logic [4:0]  column_write_latency;
   logic        dqs_clk, dq_beat, dq_last, setup_err, strobe_err;
   logic [7:0]  dq;
   logic        cmd_ack, cmd_rej, data_win, burst_chop, rec_busy, wtr_s_busy, wtr_l_busy;
   logic        st_valid, st_ok, offend, hang_risk, cfg_err, zq_busy, zq_load, zq_curr_en, park_hold;
   logic [63:0] st_data;
   logic [31:0] lfsr = 32'hCC2F9C67;
   int          err_count = 0;
   int          checks = 0;
   int          run [4] = '{0, 0, 0, 0};
   int          len [4] = '{0, 0, 0, 0};
   int          load_at = 0;
   logic [3:0]  bz;

   ddrwz_core i_dut (.sys_clk, .rst_n, .cmd_valid, .cmd_code, .cmd_bg, .cmd_ba, .chop_bit, .burst_field,
      .column_write_latency, .two_pre, .crc_en, .dm_en, .dqs_clk, .dq_beat, .dq_last, .dq, .setup_err, .strobe_err,
      .cmd_ack, .cmd_rej, .data_win, .burst_chop, .rec_busy, .wtr_s_busy, .wtr_l_busy, .st_valid,
      .st_data, .st_ok, .offend, .hang_risk, .cfg_err, .zq_busy, .zq_load, .zq_curr_en, .park_hold);
   ddrwz_dqs_model m (.dqs_clk, .dq_beat, .dq_last, .dq, .setup_err, .strobe_err);

   // Busy spans are measured beside the stimulus so no pulse start is missed.
   assign bz = {wtr_l_busy, zq_busy, wtr_s_busy, rec_busy};
   always @(posedge sys_clk)
   begin
      for (int k = 0; k < 4; k++)
      begin
         run[k] <= bz[k] ? run[k] + 1 : 0;
         if (!bz[k] && run[k] != 0)
            len[k] <= run[k];
      end
      if (zq_load)
         load_at <= run[2];
   end

   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic chopped(input logic [1:0] f, input logic c);
      return (f == BF_CHOP4) || (f == BF_OTF && !c);
   endfunction

   task automatic summarize();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic await(ref logic s, input int lim);
      for (int i = 0; i < lim && s !== 1'b1; i++)
         @(negedge sys_clk);
      `CHK(s, 1'b1)
   endtask

   task automatic cmd(input logic [2:0] c, input logic [1:0] bg, input logic ok);
      cmd_valid = 1'b1;
      cmd_code = c;
      cmd_bg = bg;
      @(negedge sys_clk);
      `CHK(cmd_ack, ok)
      `CHK(cmd_rej, !ok)
      cmd_valid = 1'b0;
      @(negedge sys_clk);
   endtask

   task automatic wr(input logic [1:0] f, input logic c, input logic se, input logic be, input logic ok);
      logic [63:0] d;
      lfsr = nxt(lfsr);
      d[63:32] = lfsr;
      lfsr = nxt(lfsr);
      d[31:0] = lfsr;
      burst_field = f;
      chop_bit = c;
      cmd(CMD_WR, 2'h1, 1'b1);
      await(data_win, 40);
      `CHK(burst_chop, chopped(f, c))
      m.send(d, chopped(f, c) ? 4 : 8, se, be);
      @(negedge sys_clk);
      await(st_valid, 10);
      `CHK(chopped(f, c) ? st_data[31:0] : st_data, chopped(f, c) ? {32'h0, d[63:32]} : d)
      `CHK(st_ok, ok)
      repeat (20) @(negedge sys_clk);
      `CHK(len[0], (crc_en && dm_en) ? 14 : 12)
      `CHK(len[1], (crc_en && dm_en) ? 5 : 3)
      `CHK(len[3], (crc_en && dm_en) ? 11 : 9)
   endtask

   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   initial
   begin
      #5000000;
      err_count++;
      summarize();
   end

   initial
   begin
      {rst_n, cmd_valid, chop_bit, two_pre, crc_en, dm_en, cmd_code, cmd_bg, cmd_ba, burst_field} = '0;
      column_write_latency = 5'h0C;
      repeat (4) @(negedge sys_clk);
      `CHK({cmd_ack, zq_busy, st_valid, offend}, 4'h0)
      rst_n = 1'b1;
      for (int f = 0; f < 3; f++)
         for (int c = 0; c < 2; c++)
         begin
            lfsr = nxt(lfsr);
            {crc_en, dm_en} = lfsr[1:0];
            wr(f[1:0], c[0], 1'b0, 1'b0, 1'b1);
         end
      {crc_en, dm_en} = 2'h0;
      $display("test bursts done");
      cmd(CMD_WR, 2'h0, 1'b1);
      cmd(CMD_WR, 2'h0, 1'b0);
      cmd(CMD_WR, 2'h1, 1'b1);
      cmd(CMD_WR, 2'h1, 1'b0);
      repeat (2) @(negedge sys_clk);
      cmd(CMD_WR, 2'h1, 1'b1);
      two_pre = 1'b1;
      column_write_latency = 5'h0A;
      repeat (4) @(negedge sys_clk);
      cmd(CMD_WR, 2'h1, 1'b0);
      cmd(CMD_WR, 2'h1, 1'b1);
      `CHK(cfg_err, 1'b0)
      column_write_latency = CWL_FORBID;
      repeat (3) @(negedge sys_clk);
      `CHK(cfg_err, 1'b1)
      two_pre = 1'b0;
      column_write_latency = 5'h0C;
      repeat (30) @(negedge sys_clk);
      $display("test spacing done");
      wr(BF_FULL8, 1'b1, 1'b1, 1'b0, 1'b0);
      `CHK(offend, 1'b1)
      cmd(CMD_RD, 2'h2, 1'b1);
      wr(BF_FULL8, 1'b1, 1'b0, 1'b0, 1'b0);
      cmd(CMD_PREA, 2'h0, 1'b1);
      `CHK(offend, 1'b0)
      wr(BF_FULL8, 1'b1, 1'b0, 1'b0, 1'b1);
      {crc_en, dm_en} = 2'h3;
      wr(BF_FULL8, 1'b1, 1'b0, 1'b1, 1'b0);
      `CHK(hang_risk, 1'b1)
      {crc_en, dm_en} = 2'h0;
      $display("test violations done");
      cmd(CMD_ACT, 2'h0, 1'b1);
      cmd(CMD_ZQS, 2'h0, 1'b0);
      cmd(CMD_PREA, 2'h0, 1'b1);
      for (int z = 0; z < 3; z++)
      begin
         cmd(z < 2 ? CMD_ZQL : CMD_ZQS, 2'h0, 1'b1);
         `CHK({zq_busy, zq_curr_en, park_hold}, 3'h7)
         cmd(CMD_RD, 2'h0, 1'b0);
         for (int i = 0; i < 1100 && zq_busy; i++)
            @(negedge sys_clk);
         repeat (2) @(negedge sys_clk);
         `CHK(len[2], z == 0 ? 1024 : (z == 1 ? 512 : 128))
         `CHK(load_at, z == 0 ? 1024 : (z == 1 ? 512 : 64))
         `CHK(zq_curr_en, 1'b0)
      end
      $display("test calibration done");
      summarize();
   end
endmodule
`default_nettype wire
